// [hw/tls_lod_select.sv]
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module tls_lod_select (
  input  wire logic                          clock,
  input  wire logic                          rstn,
  input  wire logic [tls_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [tls_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [tls_pkg::DATA_W-1:0]         reg_rdata,
  input  wire tls_pkg::tls_req_t             req,
  output tls_pkg::tls_res_t                  res
);

  // Whole module state
  typedef struct packed {
    tls_pkg::tls_cfg_t          cfg;   // Sampler and surface state
    tls_pkg::tls_res_t          res;   // Last pixel result
    logic [tls_pkg::DATA_W-1:0] rdata; // Read answer
  } tls_state_t;

  tls_state_t st_q;  // Registered state
  tls_state_t st_d;  // Next state

  // Datapath stage values
  logic signed [tls_pkg::LOD_W-1:0] biased;     // Bias stage
  logic signed [tls_pkg::LOD_W-1:0] pre_clamp;  // Clamp unit output
  logic signed [tls_pkg::LOD_W-1:0] pc_lod;     // After optional clamp
  logic signed [tls_pkg::LOD_W-1:0] adj_lod;    // After base offset
  logic signed [tls_pkg::LOD_W-1:0] quirk_lod;  // Decision operand
  logic signed [tls_pkg::LOD_W-1:0] eff_lod;    // LOD fed to selection
  logic signed [tls_pkg::LOD_W-1:0] cap_lod;    // Fraction-capped LOD
  logic                             magnify;    // Magnify decision
  logic [1:0]                       pick_mode;  // Mode used for picking
  logic [tls_pkg::LVL_W-1:0]        lo_int;     // Finest integer level
  logic [tls_pkg::LVL_W-1:0]        hi_int;     // Coarsest integer level
  logic [tls_pkg::LVL_W-1:0]        p_lvl0;     // Picked level
  logic [tls_pkg::LVL_W-1:0]        p_lvl1;     // Picked coarser level
  logic [tls_pkg::FRAC_W-1:0]       p_blend;    // Picked blend
  logic                             p_two;      // Two levels used
  logic [tls_pkg::DATA_W-1:0]       rd_mux;     // Read selection

  // Integer parts of the limits
  assign lo_int = st_q.cfg.finest_level_limit[tls_pkg::LIM_W-1:tls_pkg::FRAC_W];
  assign hi_int = st_q.cfg.coarsest_level_limit[tls_pkg::LIM_W-1:tls_pkg::FRAC_W];

  // Bias stage, message bias only on bias-type messages
  always_comb begin
    // Per-pixel LOD arrives precomputed with the request
    biased = tls_pkg::ext_s(req.lod) + tls_pkg::ext_s(st_q.cfg.state_detail_bias);
    if (req.bias_msg) begin
      biased = biased + tls_pkg::ext_s(req.message_detail_bias);
    end
  end

  // Early clamp between full fractional limits
  tls_range_clamp u_pre_clamp (
    .value   (biased),
    .lo      (st_q.cfg.finest_level_limit),
    .hi      (st_q.cfg.coarsest_level_limit),
    .clamped (pre_clamp)
  );

  // Base offset, decision and effective LOD
  always_comb begin
    pc_lod    = st_q.cfg.early_clamp_enable ? pre_clamp : biased;
    adj_lod   = pc_lod - tls_pkg::ext_u({st_q.cfg.base_level_offset, 5'h00});
    // Decision operand carries the surface first level
    quirk_lod = adj_lod + tls_pkg::ext_u({st_q.cfg.surface_first_level, 6'h00});
    magnify   = (quirk_lod <= 0);
    if (magnify || req.outside_range_flag) begin
      eff_lod   = '0;
      pick_mode = tls_pkg::TLS_IL_OFF;
    end else begin
      eff_lod   = adj_lod;
      pick_mode = st_q.cfg.inter_level_filter_select;
    end
  end

  // Fraction limits cap the blend weights
  tls_range_clamp u_cap_clamp (
    .value   (eff_lod),
    .lo      (st_q.cfg.finest_level_limit),
    .hi      (st_q.cfg.coarsest_level_limit),
    .clamped (cap_lod)
  );

  // Level selection and final clamp
  tls_level_pick u_pick (
    .lod        (eff_lod),
    .lod_capped (cap_lod),
    .mode       (pick_mode),
    .lo_int     (lo_int),
    .hi_int     (hi_int),
    .lvl0       (p_lvl0),
    .lvl1       (p_lvl1),
    .blend      (p_blend),
    .two_level  (p_two)
  );

  // Register read selection
  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      tls_pkg::OFS_CTRL: begin
        // Control fields
        rd_mux[tls_pkg::CTRL_EARLY]     = st_q.cfg.early_clamp_enable;
        rd_mux[tls_pkg::CTRL_ILF +: 2]  = st_q.cfg.inter_level_filter_select;
        rd_mux[tls_pkg::CTRL_MAG]       = st_q.cfg.magnify_filter_select;
      end
      tls_pkg::OFS_BIAS: begin
        rd_mux[tls_pkg::LIM_W-1:0] = st_q.cfg.state_detail_bias;
      end
      tls_pkg::OFS_LIMIT: begin
        // Finest low half, coarsest high half
        rd_mux[tls_pkg::LIM_W-1:0]                 = st_q.cfg.finest_level_limit;
        rd_mux[tls_pkg::LIM_HI +: tls_pkg::LIM_W]  = st_q.cfg.coarsest_level_limit;
      end
      tls_pkg::OFS_LEVEL: begin
        // Base, surface first level, count
        rd_mux[tls_pkg::BASE_W-1:0]                   = st_q.cfg.base_level_offset;
        rd_mux[tls_pkg::LVL_FIRST +: tls_pkg::LVL_W]  = st_q.cfg.surface_first_level;
        rd_mux[tls_pkg::LVL_COUNT +: tls_pkg::LVL_W]  = st_q.cfg.level_count;
      end
      tls_pkg::OFS_SIZE: begin
        // Width low half, height high half
        rd_mux[tls_pkg::DIM_W-1:0]                = st_q.cfg.width;
        rd_mux[tls_pkg::SIZE_V +: tls_pkg::DIM_W] = st_q.cfg.height;
      end
      tls_pkg::OFS_STAT: begin
        // Last result for software inspection
        rd_mux[tls_pkg::LVL_W-1:0]                    = st_q.res.lvl0;
        rd_mux[tls_pkg::STAT_L1 +: tls_pkg::LVL_W]    = st_q.res.lvl1;
        rd_mux[tls_pkg::STAT_BLEND +: tls_pkg::FRAC_W] = st_q.res.blend;
        rd_mux[tls_pkg::STAT_MAG]                     = st_q.res.magnify_decision;
        rd_mux[tls_pkg::STAT_OOB]                     = st_q.res.zero_texel;
      end
      default: begin
        rd_mux = '0; // Unmapped reads zero
      end
    endcase
  end

  // Next state
  always_comb begin
    st_d = st_q;
    // Register writes, full word
    if (reg_wr) begin
      case (reg_addr)
        tls_pkg::OFS_CTRL: begin
          // Clamp enable, filter select, magnify filter
          st_d.cfg.early_clamp_enable        = reg_wdata[tls_pkg::CTRL_EARLY];
          st_d.cfg.inter_level_filter_select = reg_wdata[tls_pkg::CTRL_ILF +: 2];
          st_d.cfg.magnify_filter_select     = reg_wdata[tls_pkg::CTRL_MAG];
        end
        tls_pkg::OFS_BIAS: begin
          st_d.cfg.state_detail_bias = reg_wdata[tls_pkg::LIM_W-1:0];
        end
        tls_pkg::OFS_LIMIT: begin
          // Both limits move together
          st_d.cfg.finest_level_limit   = reg_wdata[tls_pkg::LIM_W-1:0];
          st_d.cfg.coarsest_level_limit = reg_wdata[tls_pkg::LIM_HI +: tls_pkg::LIM_W];
        end
        tls_pkg::OFS_LEVEL: begin
          // Level count is stored only
          st_d.cfg.base_level_offset   = reg_wdata[tls_pkg::BASE_W-1:0];
          st_d.cfg.surface_first_level = reg_wdata[tls_pkg::LVL_FIRST +: tls_pkg::LVL_W];
          st_d.cfg.level_count         = reg_wdata[tls_pkg::LVL_COUNT +: tls_pkg::LVL_W];
        end
        tls_pkg::OFS_SIZE: begin
          // Edges above the largest level saturate
          st_d.cfg.width  = (reg_wdata[tls_pkg::DIM_W-1:0] > tls_pkg::MAX_DIM) ?
                            tls_pkg::MAX_DIM : reg_wdata[tls_pkg::DIM_W-1:0];
          st_d.cfg.height = (reg_wdata[tls_pkg::SIZE_V +: tls_pkg::DIM_W] > tls_pkg::MAX_DIM) ?
                            tls_pkg::MAX_DIM : reg_wdata[tls_pkg::SIZE_V +: tls_pkg::DIM_W];
        end
        default: begin
          st_d.cfg = st_q.cfg; // Writes elsewhere ignored
        end
      endcase
    end
    // Read answer stands one cycle only
    st_d.rdata = reg_rd ? rd_mux : '0;
    // Pixel result, one per request, in order
    st_d.res.valid            = req.valid;
    if (req.valid) begin
      st_d.res.magnify_decision = magnify;
      st_d.res.mag_filter       = st_q.cfg.magnify_filter_select;
      st_d.res.two_level        = p_two;
      st_d.res.lvl0             = p_lvl0;
      st_d.res.lvl1             = p_lvl1;
      st_d.res.blend            = p_blend;
      // Non power-of-two edges halve with floor
      st_d.res.dim_u            = tls_pkg::lvl_dim(st_q.cfg.width, p_lvl0);
      st_d.res.dim_v            = tls_pkg::lvl_dim(st_q.cfg.height, p_lvl0);
      st_d.res.zero_texel       = req.outside_range_flag;
      st_d.res.alpha_one        = req.outside_range_flag & req.no_alpha;
    end
  end

  // State register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q                          <= '0;
      // Coarsest limit and edges start at the largest
      st_q.cfg.coarsest_level_limit <= tls_pkg::RST_COARSEST;
      st_q.cfg.width                <= tls_pkg::MAX_DIM;
      st_q.cfg.height               <= tls_pkg::MAX_DIM;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = st_q.rdata;
  assign res       = st_q.res;

  // Checks on the datapath and register port
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // Limits ordered so clamps are meaningful
  logic lim_ok;
  assign lim_ok = (st_q.cfg.finest_level_limit <= st_q.cfg.coarsest_level_limit);

  sequence s_ctrl_wr;
    reg_wr && (reg_addr == tls_pkg::OFS_CTRL);
  endsequence

  sequence s_ctrl_rd;
    reg_rd && (reg_addr == tls_pkg::OFS_CTRL);
  endsequence

  property p_in_order;
    req.valid |=> res.valid;
  endproperty
  a_in_order: assert property (p_in_order) else $error("result missing");

  property p_idle;
    !req.valid |=> !res.valid;
  endproperty
  a_idle: assert property (p_idle) else $error("spurious result");

  property p_outside;
    req.valid && req.outside_range_flag |=> res.zero_texel && !res.two_level &&
      (res.lvl0 == tls_pkg::lvl_clamp('0, $past(lo_int), $past(hi_int)));
  endproperty
  a_outside: assert property (p_outside) else $error("outside range not zeroed");

  property p_alpha;
    req.valid |=> res.alpha_one == ($past(req.outside_range_flag) && $past(req.no_alpha));
  endproperty
  a_alpha: assert property (p_alpha) else $error("alpha substitution wrong");

  property p_final_clamp;
    res.valid && $past(lim_ok) |-> (res.lvl0 >= $past(lo_int)) && (res.lvl0 <= $past(hi_int));
  endproperty
  a_final_clamp: assert property (p_final_clamp) else $error("level outside limits");

  property p_magnify;
    res.valid && res.magnify_decision |-> !res.two_level && (res.blend == '0) &&
      (res.mag_filter == $past(st_q.cfg.magnify_filter_select));
  endproperty
  a_magnify: assert property (p_magnify) else $error("magnify not single level");

  property p_decision;
    req.valid |=> res.magnify_decision == ($past(quirk_lod) <= 0);
  endproperty
  a_decision: assert property (p_decision) else $error("decision operand wrong");

  property p_pre_clamp;
    req.valid && st_q.cfg.early_clamp_enable && lim_ok |->
      (pc_lod >= tls_pkg::ext_u(st_q.cfg.finest_level_limit)) &&
      (pc_lod <= tls_pkg::ext_u(st_q.cfg.coarsest_level_limit));
  endproperty
  a_pre_clamp: assert property (p_pre_clamp) else $error("early clamp escaped");

  property p_blend_only;
    res.valid && res.two_level |-> ($past(st_q.cfg.inter_level_filter_select) ==
      tls_pkg::TLS_IL_BLEND) && !res.magnify_decision;
  endproperty
  a_blend_only: assert property (p_blend_only) else $error("two levels outside blend");

  property p_dims;
    res.valid |-> (res.dim_u >= tls_pkg::MIN_DIM) && (res.dim_u <= tls_pkg::MAX_DIM) &&
      (res.dim_v >= tls_pkg::MIN_DIM);
  endproperty
  a_dims: assert property (p_dims) else $error("level dimension out of range");

  property p_ctrl_back;
    s_ctrl_wr ##1 s_ctrl_rd |=> reg_rdata[3:0] == $past(reg_wdata[3:0], 2);
  endproperty
  a_ctrl_back: assert property (p_ctrl_back) else $error("control readback wrong");

  property p_rd_one;
    !reg_rd |=> reg_rdata == '0;
  endproperty
  a_rd_one: assert property (p_rd_one) else $error("read data held too long");

  // Modes other than round and blend pick the finest permitted level
  property p_off_finest;
    req.valid && (pick_mode != tls_pkg::TLS_IL_ROUND) &&
      (pick_mode != tls_pkg::TLS_IL_BLEND) |=>
      res.lvl0 == tls_pkg::lvl_clamp('0, $past(lo_int), $past(hi_int));
  endproperty
  a_off_finest: assert property (p_off_finest) else $error("off mode level wrong");

  // One level leaves the second level and weight at zero
  property p_single;
    res.valid && !res.two_level |-> (res.lvl1 == '0) && (res.blend == '0);
  endproperty
  a_single: assert property (p_single) else $error("single level carries blend");

  // Result fields stand until the next result
  property p_hold;
    !req.valid |=> $stable(res.lvl0) && $stable(res.lvl1) && $stable(res.blend);
  endproperty
  a_hold: assert property (p_hold) else $error("result fields changed while idle");

endmodule
`default_nettype wire

// [hw/tls_pkg.sv]
package tls_pkg;

  // Datapath widths
  localparam int FRAC_W = 6;   // Fraction bits of every LOD value
  localparam int LOD_W  = 14;  // Signed internal LOD, room for sums
  localparam int LIM_W  = 10;  // 4.6 fields
  localparam int BASE_W = 5;   // Base offset, 4.1
  localparam int LVL_W  = 4;   // Level index
  localparam int DIM_W  = 14;  // Texel dimension
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Surface limits
  localparam logic [LVL_W-1:0]  MAX_LEVEL = 4'hD;     // Fourteen levels
  localparam logic [DIM_W-1:0]  MAX_DIM   = 14'h2000; // Largest edge
  localparam logic [DIM_W-1:0]  MIN_DIM   = 14'h0001; // One texel
  localparam logic [LOD_W-1:0]  HALF_LOD  = 14'h0020; // 0.5 for rounding
  localparam logic [LOD_W-1:0]  ONE_LOD   = 14'h0040; // Next coarser level

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_BIAS  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LIMIT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LEVEL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_SIZE  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STAT  = 8'h14;

  // Field positions
  localparam int CTRL_EARLY = 0;
  localparam int CTRL_ILF   = 1;
  localparam int CTRL_MAG   = 3;
  localparam int LIM_HI     = 16;
  localparam int LVL_FIRST  = 8;
  localparam int LVL_COUNT  = 16;
  localparam int SIZE_V     = 16;
  localparam int STAT_L1    = 4;
  localparam int STAT_BLEND = 8;
  localparam int STAT_MAG   = 16;
  localparam int STAT_OOB   = 17;

  // Reset values
  localparam logic [LIM_W-1:0] RST_COARSEST = 10'h340; // Level 13.0

  // Inter-level filter modes
  typedef enum logic [1:0] {
    TLS_IL_OFF   = 2'b00,
    TLS_IL_ROUND = 2'b01,
    TLS_IL_BLEND = 2'b10
  } tls_ilf_t;

  // Sampler and surface state
  typedef struct packed {
    logic              early_clamp_enable;
    logic [1:0]        inter_level_filter_select;
    logic              magnify_filter_select;
    logic [LIM_W-1:0]  state_detail_bias;
    logic [LIM_W-1:0]  finest_level_limit;
    logic [LIM_W-1:0]  coarsest_level_limit;
    logic [BASE_W-1:0] base_level_offset;
    logic [LVL_W-1:0]  surface_first_level;
    logic [LVL_W-1:0]  level_count;
    logic [DIM_W-1:0]  width;
    logic [DIM_W-1:0]  height;
  } tls_cfg_t;

  // One pixel request
  typedef struct packed {
    logic             valid;
    logic [LIM_W-1:0] lod;
    logic [LIM_W-1:0] message_detail_bias;
    logic             bias_msg;
    logic             outside_range_flag;
    logic             no_alpha;
  } tls_req_t;

  // One pixel result
  typedef struct packed {
    logic              valid;
    logic              magnify_decision;
    logic              mag_filter;
    logic              two_level;
    logic [LVL_W-1:0]  lvl0;
    logic [LVL_W-1:0]  lvl1;
    logic [FRAC_W-1:0] blend;
    logic [DIM_W-1:0]  dim_u;
    logic [DIM_W-1:0]  dim_v;
    logic              zero_texel;
    logic              alpha_one;
  } tls_res_t;

  // Sign extend a 4.6 field
  function automatic logic signed [LOD_W-1:0] ext_s(input logic [LIM_W-1:0] v);
    return {{(LOD_W-LIM_W){v[LIM_W-1]}}, v};
  endfunction

  // Zero extend a 4.6 field
  function automatic logic signed [LOD_W-1:0] ext_u(input logic [LIM_W-1:0] v);
    return {{(LOD_W-LIM_W){1'b0}}, v};
  endfunction

  // Integer part, saturated to the level range
  function automatic logic [LVL_W-1:0] lvl_of(input logic signed [LOD_W-1:0] v);
    if (v < 0) begin
      return '0;
    end
    if (v[LOD_W-1:FRAC_W] > {4'h0, MAX_LEVEL}) begin
      return MAX_LEVEL;
    end
    return v[FRAC_W+LVL_W-1:FRAC_W];
  endfunction

  // Level clamp between two integer limits
  function automatic logic [LVL_W-1:0] lvl_clamp(input logic [LVL_W-1:0] l,
                                                 input logic [LVL_W-1:0] lo,
                                                 input logic [LVL_W-1:0] hi);
    if (l < lo) begin
      return lo;
    end
    return (l > hi) ? hi : l;
  endfunction

  // Halved dimension, never below one texel
  function automatic logic [DIM_W-1:0] lvl_dim(input logic [DIM_W-1:0] d,
                                               input logic [LVL_W-1:0] l);
    logic [DIM_W-1:0] t;
    t = d >> l;
    return (t == '0) ? MIN_DIM : t;
  endfunction

endpackage

// [hw/tls_range_clamp.sv]
`timescale 1ns/10ps
`default_nettype none
// Clamps a signed LOD between two unsigned 4.6 limits
module tls_range_clamp (
  input  wire logic signed [tls_pkg::LOD_W-1:0] value,
  input  wire logic [tls_pkg::LIM_W-1:0]        lo,
  input  wire logic [tls_pkg::LIM_W-1:0]        hi,
  output logic signed [tls_pkg::LOD_W-1:0]      clamped
);

  // On a crossed pair, values below the low limit get the low limit and all others the high limit
  always_comb begin
    if (value < tls_pkg::ext_u(lo)) begin
      clamped = tls_pkg::ext_u(lo);
    end else if (value > tls_pkg::ext_u(hi)) begin
      clamped = tls_pkg::ext_u(hi);
    end else begin
      clamped = value;
    end
  end

endmodule
`default_nettype wire

// [hw/tls_level_pick.sv]
`timescale 1ns/10ps
`default_nettype none
// Picks mip levels and blend for one adjusted LOD
module tls_level_pick (
  input  wire logic signed [tls_pkg::LOD_W-1:0] lod,
  input  wire logic signed [tls_pkg::LOD_W-1:0] lod_capped,
  input  wire logic [1:0]                       mode,
  input  wire logic [tls_pkg::LVL_W-1:0]        lo_int,
  input  wire logic [tls_pkg::LVL_W-1:0]        hi_int,
  output logic [tls_pkg::LVL_W-1:0]             lvl0,
  output logic [tls_pkg::LVL_W-1:0]             lvl1,
  output logic [tls_pkg::FRAC_W-1:0]            blend,
  output logic                                  two_level
);

  // Mode select then final integer clamp
  always_comb begin
    lvl0      = '0;
    lvl1      = '0;
    blend     = '0;
    two_level = 1'b0;
    case (mode)
      tls_pkg::TLS_IL_ROUND: begin
        lvl0 = tls_pkg::lvl_of(lod + tls_pkg::HALF_LOD);
      end
      tls_pkg::TLS_IL_BLEND: begin
        // Fraction clamped by fractional limits
        lvl0      = tls_pkg::lvl_of(lod_capped);
        lvl1      = tls_pkg::lvl_of(lod_capped + tls_pkg::ONE_LOD);
        blend     = (lod_capped < 0) ? '0 : lod_capped[tls_pkg::FRAC_W-1:0];
        two_level = 1'b1;
      end
      default: begin
        lvl0 = '0;
      end
    endcase
    lvl0 = tls_pkg::lvl_clamp(lvl0, lo_int, hi_int);
    lvl1 = two_level ? tls_pkg::lvl_clamp(lvl1, lo_int, hi_int) : '0;
  end

endmodule
`default_nettype wire

// [bench/tls_eu_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Shader-side model: issues pixel requests
module tls_eu_model (
  input  wire logic             clock,
  output var tls_pkg::tls_req_t req
);
  // Idle at time zero
  initial begin
    req = '0;
  end

  // Raise one request after an edge, lod and bias are S4.6
  task automatic send(input logic [9:0] lod, input logic [9:0] msg, input logic bm,
                      input logic oob, input logic na);
    @(posedge clock);
    req <= '{valid: 1'b1, lod: lod, message_detail_bias: msg, bias_msg: bm,
             outside_range_flag: oob, no_alpha: na};
  endtask

  // Release: fields stop showing the last request
  task automatic stop();
    @(posedge clock);
    req <= {1'b0, ~req[22:0]};
  endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic              clock;      // System clock
  logic              rstn;       // Async reset, low
  logic              reg_wr;     // Write strobe
  logic              reg_rd;     // Read strobe
  logic [7:0]        reg_addr;   // Byte offset
  logic [31:0]       reg_wdata;  // Write data
  logic [31:0]       reg_rdata;  // Read data
  tls_pkg::tls_req_t req;        // Pixel request
  tls_pkg::tls_res_t res;        // Pixel result
  int                bad_count;  // Mismatches
  int                n_checks;   // Comparisons
  int                cycles = 0; // Hang guard

  // 50 MHz clock
  initial clock = 1'b0;
  always #10 clock = ~clock;

  tls_lod_select u_dut (
    .clock    (clock),
    .rstn     (rstn),
    .reg_addr (reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr   (reg_wr),
    .reg_rd   (reg_rd),
    .reg_rdata(reg_rdata),
    .req      (req),
    .res      (res)
  );

  tls_eu_model u_eu (
    .clock(clock),
    .req  (req)
  );

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Word compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Pixel result compare
  task automatic chk_res(input logic m, input logic t, input logic [3:0] l0,
                         input logic [3:0] l1, input logic [5:0] bl);
    chk({13'h0, res.valid, res.magnify_decision, res.two_level, res.lvl0, res.lvl1,
         2'h0, res.blend}, {13'h0, 1'b1, m, t, l0, l1, 2'h0, bl});
  endtask

  // One-cycle write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Single pixel, result settled afterwards
  task automatic pxo(input logic [9:0] lod, input logic [9:0] msg, input logic bm,
                     input logic oob, input logic na);
    u_eu.send(lod, msg, bm, oob, na);
    u_eu.stop();
    #1;
  endtask

  // Plain pixel with expected result
  task automatic px(input logic [9:0] lod, input logic m, input logic t,
                    input logic [3:0] l0, input logic [3:0] l1, input logic [5:0] bl);
    pxo(lod, 10'h000, 1'b0, 1'b0, 1'b0);
    chk_res(m, t, l0, l1, bl);
  endtask

  // Cut a hang short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // Main sequence
  initial begin
    rstn      = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    bad_count = 0;
    n_checks  = 0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    rd(tls_pkg::OFS_LIMIT, 32'h03400000);
    rd(tls_pkg::OFS_CTRL, 32'h0);
    rd(8'h24, 32'h0);
    px(10'h080, 1'b0, 1'b0, 4'h0, 4'h0, 6'h00);
    chk({18'h0, res.dim_u}, 32'h2000);
    wr(tls_pkg::OFS_CTRL, 32'h8);
    px(10'h000, 1'b1, 1'b0, 4'h0, 4'h0, 6'h00);
    chk({31'h0, res.mag_filter}, 32'h1);
    wr(tls_pkg::OFS_CTRL, 32'h2);
    wr(tls_pkg::OFS_BIAS, 32'h3C0);
    pxo(10'h040, 10'h040, 1'b0, 1'b0, 1'b0);
    chk_res(1'b1, 1'b0, 4'h0, 4'h0, 6'h00);
    pxo(10'h040, 10'h040, 1'b1, 1'b0, 1'b0);
    chk_res(1'b0, 1'b0, 4'h1, 4'h0, 6'h00);
    wr(tls_pkg::OFS_BIAS, 32'h1C0);
    px(10'h1FF, 1'b0, 1'b0, 4'hD, 4'h0, 6'h00);
    chk({18'h0, res.dim_u}, 32'h1);
    wr(tls_pkg::OFS_BIAS, 32'h0);
    px(10'h0A0, 1'b0, 1'b0, 4'h3, 4'h0, 6'h00);
    px(10'h09F, 1'b0, 1'b0, 4'h2, 4'h0, 6'h00);
    wr(tls_pkg::OFS_SIZE, 32'h000303E8);
    px(10'h0C0, 1'b0, 1'b0, 4'h3, 4'h0, 6'h00);
    chk({2'h0, res.dim_v, 2'h0, res.dim_u}, 32'h0001007D);
    wr(tls_pkg::OFS_CTRL, 32'h4);
    px(10'h0D0, 1'b0, 1'b1, 4'h3, 4'h4, 6'h10);
    wr(tls_pkg::OFS_LIMIT, 32'h03400120);
    px(10'h100, 1'b0, 1'b1, 4'h4, 4'h5, 6'h20);
    wr(tls_pkg::OFS_LIMIT, 32'h00800000);
    px(10'h140, 1'b0, 1'b1, 4'h2, 4'h2, 6'h00);
    wr(tls_pkg::OFS_CTRL, 32'h2);
    wr(tls_pkg::OFS_LIMIT, 32'h03400060);
    px(10'h000, 1'b1, 1'b0, 4'h1, 4'h0, 6'h00);
    wr(tls_pkg::OFS_CTRL, 32'h3);
    px(10'h000, 1'b0, 1'b0, 4'h2, 4'h0, 6'h00);
    wr(tls_pkg::OFS_CTRL, 32'h2);
    wr(tls_pkg::OFS_LIMIT, 32'h03400000);
    wr(tls_pkg::OFS_LEVEL, 32'h4);
    px(10'h0C0, 1'b0, 1'b0, 4'h1, 4'h0, 6'h00);
    px(10'h080, 1'b1, 1'b0, 4'h0, 4'h0, 6'h00);
    wr(tls_pkg::OFS_LEVEL, 32'h000F0200);
    rd(tls_pkg::OFS_LEVEL, 32'h000F0200);
    px(10'h3C0, 1'b0, 1'b0, 4'h0, 4'h0, 6'h00);
    px(10'h380, 1'b1, 1'b0, 4'h0, 4'h0, 6'h00);
    wr(tls_pkg::OFS_LEVEL, 32'h0);
    pxo(10'h100, 10'h000, 1'b0, 1'b1, 1'b1);
    chk({26'h0, res.lvl0, res.zero_texel, res.alpha_one}, 32'h3);
    pxo(10'h100, 10'h000, 1'b0, 1'b1, 1'b0);
    chk({26'h0, res.lvl0, res.zero_texel, res.alpha_one}, 32'h2);
    wr(tls_pkg::OFS_CTRL, 32'h6);
    px(10'h080, 1'b0, 1'b0, 4'h0, 4'h0, 6'h00);
    wr(tls_pkg::OFS_CTRL, 32'h2);
    // Back-to-back pixels, results in order
    u_eu.send(10'h040, 10'h000, 1'b0, 1'b0, 1'b0);
    u_eu.send(10'h0C0, 10'h000, 1'b0, 1'b0, 1'b0);
    #1;
    chk_res(1'b0, 1'b0, 4'h1, 4'h0, 6'h00);
    u_eu.stop();
    #1;
    chk_res(1'b0, 1'b0, 4'h3, 4'h0, 6'h00);
    // Write then read with no gap between strobes
    @(posedge clock);
    reg_addr  <= tls_pkg::OFS_CTRL;
    reg_wdata <= 32'h5;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, 32'h5);
    rd(tls_pkg::OFS_STAT, 32'h3);
    report_and_stop();
  end
endmodule
`default_nettype wire
